// ==== dv/cfdt_can_node.sv ====
// Behavioural transmit engine and bus node at the far side of the pending logic.
// Assumes the design's clock and reset; it sends one frame at a time.
`timescale 1ns/1ps
`default_nettype none
module cfdt_can_node
  import cfdt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic txSelValid,
  input wire logic [4:0] txSelIdx,
  input wire logic slowTx,
  output logic txActive,
  output logic [4:0] txActiveIdx,
  output logic txDone,
  output logic txDoneOk,
  output logic [4:0] txDoneIdx,
  output logic canRx
);
  // ********************
  // Frame sequencer
  // ********************
  logic [6:0] frameCnt;
  // The receive line idles recessive through the bus pull-up.
  assign canRx = 1'b1;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txActive <= 1'b0;
      txActiveIdx <= 5'h0;
      txDone <= 1'b0;
      txDoneOk <= 1'b0;
      txDoneIdx <= 5'h0;
      frameCnt <= 7'h0;
    end else begin
      // Outside the done pulse the qualifier and index change every cycle.
      txDone <= 1'b0;
      txDoneOk <= ~txDoneOk;
      txDoneIdx <= ~txDoneIdx;
      if (txSelValid && !txActive) begin
        txActive <= 1'b1;
        txActiveIdx <= txSelIdx;
        frameCnt <= slowTx ? 7'h3c : 7'h06;
      end else if (txActive && frameCnt == 7'h0) begin
        txActive <= 1'b0;
        txDone <= 1'b1;
        txDoneOk <= 1'b1;
        txDoneIdx <= txActiveIdx;
      end else if (txActive) begin
        frameCnt <= frameCnt - 7'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench of the data timing and transmit pending block.
// Assumes the design package, defines header and the bus node model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cfdt_defines.svh"
module testbench
  import cfdt_pkg::*;
;
  // ********************
  // Signals and instances
  // ********************
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, slowTx;
  logic awready, wready, bvalid, arready, rvalid, tqTick, samplePoint, bitStart, txSelValid, irq;
  logic canRx, txActive, txDone, txDoneOk;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, s2;
  logic [1:0] bresp, rresp;
  logic [4:0] txSelIdx, txActiveIdx, txDoneIdx, p, s1;
  logic [2:0] j;
  logic [10:0] ids [4] = '{11'h300, 11'h120, 11'h120, 11'h7ff};
  logic [33:0] rdQ [$];
  logic [1:0] bQ [$];
  logic [4:0] selQ [$];
  int failures, checks_done, n;
  cfdt_top i_cfdt_top(.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .canRx(canRx), .tqTick(tqTick), .samplePoint(samplePoint),
    .bitStart(bitStart), .txSelValid(txSelValid), .txSelIdx(txSelIdx), .txActive(txActive),
    .txActiveIdx(txActiveIdx), .txDone(txDone), .txDoneOk(txDoneOk), .txDoneIdx(txDoneIdx), .irq(irq));
  cfdt_can_node i_cfdt_can_node(.clk(clk), .rstn(rstn), .txSelValid(txSelValid), .txSelIdx(txSelIdx),
    .slowTx(slowTx), .txActive(txActive), .txActiveIdx(txActiveIdx), .txDone(txDone), .txDoneOk(txDoneOk),
    .txDoneIdx(txDoneIdx), .canRx(canRx));
  // ********************
  // Tasks
  // ********************
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [31:0] dbtp(input logic [4:0] a, b, input logic [3:0] c, input logic [2:0] d);
    return {11'h0, a, 3'h0, b, c, 1'h0, d};
  endfunction
  function automatic logic [31:0] idw(input logic [4:0] k, input logic [10:0] id);
    return {3'h0, k, 13'h0, id};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    bQ.push_back(er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(negedge clk); while (!bvalid);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rdQ.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
    rready <= 1'b0;
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? tqTick : (k == 1 ? samplePoint : bitStart);
  endfunction
  task automatic span(input int a, input int b, output int c);
    do @(negedge clk); while (!sig(a));
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (!sig(b));
  endtask
  task automatic waitDone();
    do @(negedge clk); while (!txDone);
    repeat (2) @(posedge clk);
  endtask
  // ********************
  // Result monitor, clock and watchdog
  // ********************
  always @(negedge clk) begin
    if (rvalid && rready) chk("rdata", rdQ.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", 34'(bQ.pop_front()), 34'(bresp));
    if (txSelValid) chk("txSelIdx", 34'(selQ.pop_front()), 34'(txSelIdx));
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end
  // ********************
  // Main sequence
  // ********************
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, slowTx} = 7'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    failures = 0;
    checks_done = 0;
    n = $urandom(32'hd379);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(`CFDT_OFF_TXBRP, 34'h0);
    rd(`CFDT_OFF_DBTP, {2'h0, `CFDT_DBTP_RST});
    rd(8'h40, {`CFDT_RESP_ERR, 32'h0});
    wr(8'h40, 32'h1, `CFDT_RESP_ERR);
    p = 5'($urandom % 4);
    s1 = 5'(1 + $urandom % 6);
    s2 = 4'($urandom % 8);
    j = 3'($urandom % 8);
    wr(`CFDT_OFF_DBTP, dbtp(p, s1, s2, j), `CFDT_RESP_OK);
    wr(`CFDT_OFF_DBTP, dbtp(p, 5'h0, s2, j), `CFDT_RESP_OK);
    rd(`CFDT_OFF_DBTP, {2'h0, dbtp(p, s1, s2, j)});
    span(2, 2, n);
    span(0, 0, n);
    chk("quantum", 34'(p + 1), 34'(n));
    span(1, 2, n);
    chk("after", 34'((s2 + 1) * (p + 1)), 34'(n));
    span(2, 1, n);
    chk("before", 34'((s1 + 2) * (p + 1)), 34'(n));
    wr(`CFDT_OFF_IRQMSK, 32'h3, `CFDT_RESP_OK);
    wr(`CFDT_OFF_TXBC, 32'h4, `CFDT_RESP_OK);
    wr(`CFDT_OFF_TXBAR, 32'h400, `CFDT_RESP_OK);
    rd(`CFDT_OFF_TXBRP, 34'h0);
    for (int k = 0; k < 4; k++) wr(`CFDT_OFF_IDWR, idw(5'(k), ids[k]), `CFDT_RESP_OK);
    slowTx <= 1'b1;
    selQ.push_back(5'd1);
    wr(`CFDT_OFF_TXBAR, 32'hf, `CFDT_RESP_OK);
    do @(negedge clk); while (!txActive);
    wr(`CFDT_OFF_TXBCR, 32'hf, `CFDT_RESP_OK);
    rd(`CFDT_OFF_TXBRP, 34'h2);
    waitDone();
    rd(`CFDT_OFF_TXBRP, 34'h0);
    rd(`CFDT_OFF_TXBCR, 34'h0);
    rd(`CFDT_OFF_TXBTO, 34'h2);
    rd(`CFDT_OFF_TXBCF, 34'hf);
    @(negedge clk);
    chk("irq", 34'h1, 34'(irq));
    wr(`CFDT_OFF_IRQST, 32'h3, `CFDT_RESP_OK);
    rd(`CFDT_OFF_IRQST, 34'h0);
    @(negedge clk);
    chk("irq", 34'h0, 34'(irq));
    slowTx <= 1'b0;
    wr(`CFDT_OFF_IRQMSK, 32'h0, `CFDT_RESP_OK);
    wr(`CFDT_OFF_TXBC, 32'h20, `CFDT_RESP_OK);
    wr(`CFDT_OFF_IDWR, idw(5'd5, 11'h200), `CFDT_RESP_OK);
    wr(`CFDT_OFF_IDWR, idw(5'd6, 11'h010), `CFDT_RESP_OK);
    selQ.push_back(5'd5);
    wr(`CFDT_OFF_TXBAR, 32'h20, `CFDT_RESP_OK);
    wr(`CFDT_OFF_TXBAR, 32'h40, `CFDT_RESP_OK);
    wr(`CFDT_OFF_TXBCR, 32'h40, `CFDT_RESP_OK);
    rd(`CFDT_OFF_TXBRP, 34'h20);
    waitDone();
    rd(`CFDT_OFF_TXBRP, 34'h0);
    rd(`CFDT_OFF_TXBTO, 34'h22);
    rd(`CFDT_OFF_TXBCF, 34'h4f);
    rd(`CFDT_OFF_IRQST, 34'h3);
    @(negedge clk);
    chk("irq", 34'h0, 34'(irq));
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== inc/cfdt_defines.svh ====
// Offsets, field positions, reset values and sizes of the CAN FD data timing and transmit pending block.
// Included by bare name from the bench and the logic files.
`ifndef CFDT_DEFINES_SVH
`define CFDT_DEFINES_SVH
`define CFDT_NBUF 32
`define CFDT_IDW 11
`define CFDT_OFF_DBTP 8'h0c
`define CFDT_OFF_TXBC 8'hc0
`define CFDT_OFF_TXBRP 8'hcc
`define CFDT_OFF_TXBAR 8'hd0
`define CFDT_OFF_TXBCR 8'hd4
`define CFDT_OFF_TXBTO 8'hd8
`define CFDT_OFF_TXBCF 8'hdc
`define CFDT_OFF_IRQST 8'he0
`define CFDT_OFF_IRQMSK 8'he4
`define CFDT_OFF_IDWR 8'he8
`define CFDT_F_DATA_RATE_PRESCALER 20:16
`define CFDT_F_SEG1 12:8
`define CFDT_F_SEG2 7:4
`define CFDT_F_SJW 2:0
`define CFDT_F_BUFN 5:0
`define CFDT_F_IDX 28:24
`define CFDT_F_ID 10:0
`define CFDT_DBTP_RST 32'h00000a33
`define CFDT_TXBC_RST 6'h20
`define CFDT_RESP_OK 2'h0
`define CFDT_RESP_ERR 2'h2
`endif

// ==== inc/cfdt_pkg.sv ====
// Types shared by the CAN FD data timing and transmit pending block.
// Assumes the defines header is compiled alongside.
package cfdt_pkg;
  typedef enum logic [1:0] {SCAN_IDLE, SCAN_RUN, SCAN_LAST, SCAN_EMIT} cfdt_scan_e;
  typedef enum logic [1:0] {SEG_SYNC, SEG_BEFORE, SEG_AFTER} cfdt_seg_e;
endpackage

// ==== logic/cfdt_id_mem.sv ====
// Message identifier store of the 32 transmit buffers.
// Assumes one clock; read data appear one cycle after the read address.
`timescale 1ns/1ps
`default_nettype none
`include "cfdt_defines.svh"
module cfdt_id_mem
  import cfdt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [`CFDT_IDW-1:0] wdata,
  input wire logic [4:0] raddr,
  output logic [`CFDT_IDW-1:0] rdata
);
  logic [`CFDT_IDW-1:0] mem [0:`CFDT_NBUF-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 11'h000;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// ==== logic/cfdt_top.sv ====
// CAN FD data phase bit timing and transmit request pending logic with an AXI4-Lite register slave.
// Assumes one clock, an asynchronous reset and a transmit engine on the same clock.
//
// Operation
// - The time quantum is the clock divided by the prescaler field in bits 20:16 plus one, values 0 to 31.
// - The segment before the sample point lasts the field in bits 12:8 plus one quanta, and zero is never taken.
// - The segment after the sample point lasts the field in bits 7:4 plus one quanta.
// - A resynchronisation moves the bit by at most the field in bits 2:0 plus one quanta.
// - Each of the 32 buffers has a pending flag, set only by writing a one to its add request bit.
// - Add requests for buffers beyond the configured count are ignored.
// - Setting a pending flag starts a scan that picks the pending buffer with the lowest identifier.
// - Flags set during a running scan wait for a later scan.
// - A cancel for a buffer not under transmission clears its pending flag at once.
// - A pending flag clears on completed transmission or on an effective cancel.
// - A cancel of a buffer under transmission waits for the end of that transmission.
// - Each cancel request bit clears right after its pending flag has cleared.
// - The cancel finished flag sets on a cancel before start or on success together with the occurred flag.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cfdt_defines.svh"
module cfdt_top
  import cfdt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic canRx,
  output logic tqTick,
  output logic samplePoint,
  output logic bitStart,
  output logic txSelValid,
  output logic [4:0] txSelIdx,
  input wire logic txActive,
  input wire logic [4:0] txActiveIdx,
  input wire logic txDone,
  input wire logic txDoneOk,
  input wire logic [4:0] txDoneIdx,
  output logic irq
);
  logic [7:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic awHave;
  logic wHave;
  logic wrDo;
  logic [31:0] wrVal;
  logic [31:0] rdMux;
  logic dbtpWr;
  logic addWr;
  logic cancelWr;
  logic [31:0] dbtpReg;
  logic [5:0] cfgReg;
  logic [31:0] cfgMask;
  logic [31:0] pendReg;
  logic [31:0] cancelReg;
  logic [31:0] toReg;
  logic [31:0] cfReg;
  logic [31:0] snapReg;
  logic [1:0] irqStReg;
  logic [1:0] irqMskReg;
  logic [31:0] addSet;
  logic [31:0] cancelSet;
  logic [31:0] cancelAll;
  logic [31:0] busyMask;
  logic [31:0] doneMask;
  logic [31:0] doneOk;
  logic [31:0] cancelNow;
  logic [31:0] cancelAtEnd;
  logic [31:0] pendClr;
  logic [31:0] cfSet;
  logic [31:0] retry;
  cfdt_scan_e scanState;
  logic scanReq;
  logic [4:0] scanIdx;
  logic [4:0] cmpIdx;
  logic cmpVld;
  logic bestVld;
  logic [4:0] bestIdx;
  logic [`CFDT_IDW-1:0] bestId;
  logic [`CFDT_IDW-1:0] memId;
  logic [4:0] divCnt;
  logic rxMeta;
  logic rxSync;
  logic rxPrev;
  logic rxEdge;
  cfdt_seg_e segState;
  logic [5:0] segCnt;
  logic [5:0] segTgt;
  logic [5:0] tgtEff;
  logic [5:0] jump;
  logic resyncUsed;

  function automatic logic isMapped(input logic [7:0] a);
    case (a)
      `CFDT_OFF_DBTP, `CFDT_OFF_TXBC, `CFDT_OFF_TXBRP, `CFDT_OFF_TXBAR, `CFDT_OFF_TXBCR,
      `CFDT_OFF_TXBTO, `CFDT_OFF_TXBCF, `CFDT_OFF_IRQST, `CFDT_OFF_IRQMSK, `CFDT_OFF_IDWR: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] oneHot(input logic [4:0] i);
    oneHot = 32'h00000001 << i;
  endfunction

  // ************************************************************
  // AXI4-Lite slave.
  // ************************************************************
  assign awready = !awHave && !bvalid;
  assign wready = !wHave && !bvalid;
  assign arready = !rvalid;
  assign wrDo = awHave && wHave && !bvalid;
  assign wrVal = wDataReg & {{8{wStrbReg[3]}}, {8{wStrbReg[2]}}, {8{wStrbReg[1]}}, {8{wStrbReg[0]}}};
  assign dbtpWr = wrDo && awAddrReg == `CFDT_OFF_DBTP;
  assign addWr = wrDo && awAddrReg == `CFDT_OFF_TXBAR;
  assign cancelWr = wrDo && awAddrReg == `CFDT_OFF_TXBCR;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg <= 32'h00000000;
      wStrbReg <= 4'h0;
    end else begin
      if (wrDo) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
      end else begin
        if (awvalid && awready) begin
          awHave <= 1'b1;
          awAddrReg <= awaddr;
        end
        if (wvalid && wready) begin
          wHave <= 1'b1;
          wDataReg <= wdata;
          wStrbReg <= wstrb;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp <= `CFDT_RESP_OK;
    end else if (wrDo) begin
      bvalid <= 1'b1;
      bresp <= isMapped(awAddrReg) ? `CFDT_RESP_OK : `CFDT_RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_comb begin
    case (araddr)
      `CFDT_OFF_DBTP: rdMux = dbtpReg;
      `CFDT_OFF_TXBC: rdMux = {26'h0000000, cfgReg};
      `CFDT_OFF_TXBRP: rdMux = pendReg;
      `CFDT_OFF_TXBCR: rdMux = cancelReg;
      `CFDT_OFF_TXBTO: rdMux = toReg;
      `CFDT_OFF_TXBCF: rdMux = cfReg;
      `CFDT_OFF_IRQST: rdMux = {30'h00000000, irqStReg};
      `CFDT_OFF_IRQMSK: rdMux = {30'h00000000, irqMskReg};
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `CFDT_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rdMux;
      rresp <= isMapped(araddr) ? `CFDT_RESP_OK : `CFDT_RESP_ERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Configuration registers and interrupt.
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dbtpReg <= `CFDT_DBTP_RST;
      cfgReg <= `CFDT_TXBC_RST;
      irqMskReg <= 2'h0;
    end else if (wrDo) begin
      if (dbtpWr) begin
        dbtpReg[`CFDT_F_DATA_RATE_PRESCALER] <= wrVal[`CFDT_F_DATA_RATE_PRESCALER];
        if (wrVal[`CFDT_F_SEG1] != 5'h00) begin
          dbtpReg[`CFDT_F_SEG1] <= wrVal[`CFDT_F_SEG1];
        end
        dbtpReg[`CFDT_F_SEG2] <= wrVal[`CFDT_F_SEG2];
        dbtpReg[`CFDT_F_SJW] <= wrVal[`CFDT_F_SJW];
      end
      if (awAddrReg == `CFDT_OFF_TXBC) begin
        cfgReg <= wrVal[5] ? `CFDT_TXBC_RST : wrVal[`CFDT_F_BUFN];
      end
      if (awAddrReg == `CFDT_OFF_IRQMSK) begin
        irqMskReg <= wrVal[1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CFDT_NBUF; gi++) begin : g_cfg
      assign cfgMask[gi] = 6'(gi) < cfgReg;
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqStReg <= 2'h0;
    end else begin
      irqStReg <= (irqStReg & ~((wrDo && awAddrReg == `CFDT_OFF_IRQST) ? wrVal[1:0] : 2'h0)) | {|cfSet, |doneOk};
    end
  end

  assign irq = |(irqStReg & irqMskReg);

  // ************************************************************
  // Pending flags, cancellation and completion.
  // ************************************************************
  assign addSet = addWr ? (wrVal & cfgMask) : 32'h00000000;
  assign cancelSet = cancelWr ? (wrVal & pendReg) : 32'h00000000;
  assign cancelAll = cancelReg | cancelSet;
  assign doneMask = txDone ? oneHot(txDoneIdx) : 32'h00000000;
  assign busyMask = (txActive ? oneHot(txActiveIdx) : 32'h00000000) | doneMask;
  assign doneOk = txDoneOk ? (doneMask & pendReg) : 32'h00000000;
  assign cancelNow = cancelAll & pendReg & ~busyMask;
  assign cancelAtEnd = cancelAll & doneMask & pendReg;
  assign pendClr = cancelNow | cancelAtEnd | doneOk;
  assign cfSet = cancelNow | (cancelAtEnd & doneOk);
  assign retry = doneMask & pendReg & ~doneOk & ~cancelAll;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pendReg <= 32'h00000000;
      cancelReg <= 32'h00000000;
      toReg <= 32'h00000000;
      cfReg <= 32'h00000000;
    end else begin
      pendReg <= (pendReg & ~pendClr) | addSet;
      cancelReg <= (cancelReg & pendReg) | cancelSet;
      toReg <= (toReg & ~addSet) | doneOk;
      cfReg <= (cfReg & ~addSet) | cfSet;
    end
  end

  pend_add_a: assert property (@(posedge clk) disable iff (!rstn)
    |(pendReg & ~$past(pendReg)) |-> $past(addWr)) else $error("pending flag set without add write");
  cfg_range_a: assert property (@(posedge clk) disable iff (!rstn)
    (pendReg & ~$past(pendReg) & ~$past(cfgMask)) == 32'h00000000) else $error("pending set outside config");
  cancel_now_a: assert property (@(posedge clk) disable iff (!rstn)
    |cancelNow |=> (pendReg & $past(cancelNow) & ~$past(addSet)) == 32'h00000000) else $error("cancel not at once");
  done_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    txDone && txDoneOk && pendReg[txDoneIdx] && !addSet[txDoneIdx] |=>
    !pendReg[$past(txDoneIdx)] && toReg[$past(txDoneIdx)]) else $error("done did not clear pending");
  tx_wait_a: assert property (@(posedge clk) disable iff (!rstn)
    txActive && !txDone && pendReg[txActiveIdx] |=> pendReg[$past(txActiveIdx)]) else $error("cleared mid frame");
  cancel_drop_a: assert property (@(posedge clk) disable iff (!rstn)
    (cancelReg & ~$past(pendReg)) == 32'h00000000) else $error("cancel bit outlived pending");
  cf_set_a: assert property (@(posedge clk) disable iff (!rstn)
    txDone && txDoneOk && cancelReg[txDoneIdx] && pendReg[txDoneIdx] |=>
    cfReg[$past(txDoneIdx)] && toReg[$past(txDoneIdx)]) else $error("cancel finished not set");

  // ************************************************************
  // Transmit scan over the identifier store.
  // ************************************************************
  cfdt_id_mem u_mem (
    .clk(clk),
    .rstn(rstn),
    .we(wrDo && awAddrReg == `CFDT_OFF_IDWR),
    .waddr(wrVal[`CFDT_F_IDX]),
    .wdata(wrVal[`CFDT_F_ID]),
    .raddr(scanIdx),
    .rdata(memId)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scanState <= SCAN_IDLE;
      scanReq <= 1'b0;
      scanIdx <= 5'h00;
      snapReg <= 32'h00000000;
      txSelValid <= 1'b0;
    end else begin
      txSelValid <= 1'b0;
      if (|addSet || |retry) begin
        scanReq <= 1'b1;
      end else if (scanState == SCAN_IDLE) begin
        scanReq <= 1'b0;
      end
      unique case (scanState)
        SCAN_IDLE: begin
          if (scanReq) begin
            snapReg <= pendReg & ~pendClr;
            scanIdx <= 5'h00;
            scanState <= SCAN_RUN;
          end
        end
        SCAN_RUN: begin
          scanIdx <= scanIdx + 5'h01;
          if (scanIdx == 5'h1f) begin
            scanState <= SCAN_LAST;
          end
        end
        SCAN_LAST: begin
          scanState <= SCAN_EMIT;
        end
        SCAN_EMIT: begin
          txSelValid <= bestVld && pendReg[bestIdx];
          scanState <= SCAN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmpVld <= 1'b0;
      cmpIdx <= 5'h00;
      bestVld <= 1'b0;
      bestIdx <= 5'h00;
      bestId <= 11'h000;
      txSelIdx <= 5'h00;
    end else begin
      cmpVld <= scanState == SCAN_RUN;
      cmpIdx <= scanIdx;
      if (scanState == SCAN_IDLE) begin
        bestVld <= 1'b0;
      end else if (cmpVld && snapReg[cmpIdx] && pendReg[cmpIdx] && (!bestVld || memId < bestId)) begin
        bestVld <= 1'b1;
        bestIdx <= cmpIdx;
        bestId <= memId;
      end
      if (scanState == SCAN_EMIT) begin
        txSelIdx <= bestIdx;
      end
    end
  end

  scan_start_a: assert property (@(posedge clk) disable iff (!rstn)
    |addSet && scanState == SCAN_IDLE |-> ##[1:2] scanState == SCAN_RUN) else $error("scan did not start");
  snap_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    scanState != SCAN_IDLE && $past(scanState) != SCAN_IDLE |-> snapReg == $past(snapReg)) else $error("snapshot moved");

  // ************************************************************
  // Data phase bit timing.
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt <= 5'h00;
      tqTick <= 1'b0;
    end else if (divCnt >= dbtpReg[`CFDT_F_DATA_RATE_PRESCALER]) begin
      divCnt <= 5'h00;
      tqTick <= 1'b1;
    end else begin
      divCnt <= divCnt + 5'h01;
      tqTick <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      rxMeta <= canRx;
      rxSync <= rxMeta;
      rxPrev <= rxSync;
    end
  end

  assign rxEdge = rxPrev && !rxSync;

  always_comb begin
    jump = {3'h0, dbtpReg[`CFDT_F_SJW]} + 6'h01;
    tgtEff = segTgt;
    if (rxEdge && !resyncUsed) begin
      if (segState == SEG_BEFORE) begin
        tgtEff = segTgt + ((segCnt + 6'h01 < jump) ? segCnt + 6'h01 : jump);
      end else if (segState == SEG_AFTER) begin
        tgtEff = (segTgt - segCnt <= jump) ? segCnt : segTgt - jump;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      segState <= SEG_SYNC;
      segCnt <= 6'h00;
      segTgt <= 6'h00;
      resyncUsed <= 1'b0;
      samplePoint <= 1'b0;
      bitStart <= 1'b0;
    end else begin
      samplePoint <= 1'b0;
      bitStart <= 1'b0;
      segTgt <= tgtEff;
      resyncUsed <= resyncUsed || (rxEdge && segState != SEG_SYNC);
      if (tqTick) begin
        segCnt <= segCnt + 6'h01;
        unique case (segState)
          SEG_SYNC: begin
            segState <= SEG_BEFORE;
            segCnt <= 6'h00;
            segTgt <= {1'b0, dbtpReg[`CFDT_F_SEG1]};
          end
          SEG_BEFORE: begin
            if (segCnt >= tgtEff) begin
              segState <= SEG_AFTER;
              segCnt <= 6'h00;
              segTgt <= {2'h0, dbtpReg[`CFDT_F_SEG2]};
              samplePoint <= 1'b1;
            end
          end
          SEG_AFTER: begin
            if (segCnt >= tgtEff) begin
              segState <= SEG_SYNC;
              segCnt <= 6'h00;
              resyncUsed <= 1'b0;
              bitStart <= 1'b1;
            end
          end
          default: begin
            segState <= SEG_SYNC;
          end
        endcase
      end
    end
  end

  prescale_tick_a: assert property (@(posedge clk) disable iff (!rstn)
    tqTick && dbtpReg[`CFDT_F_DATA_RATE_PRESCALER] == 5'h02 && !dbtpWr |=> !tqTick [*2] ##1 tqTick) else $error("bad quantum");
  seg1_nonzero_a: assert property (@(posedge clk) disable iff (!rstn)
    dbtpReg[`CFDT_F_SEG1] != 5'h00) else $error("segment before sample point is zero");
  seg2_load_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(segState == SEG_AFTER) && !$past(dbtpWr) |-> segTgt == {2'h0, dbtpReg[`CFDT_F_SEG2]})
    else $error("segment after sample point wrong");
  sjw_limit_a: assert property (@(posedge clk) disable iff (!rstn)
    segState == SEG_BEFORE && $past(segState) == SEG_BEFORE && !$past(dbtpWr) |->
    segTgt <= $past(segTgt) + {3'h0, dbtpReg[`CFDT_F_SJW]} + 6'h01) else $error("jump too wide");
endmodule
`default_nettype wire
